// ---- core/ccsu_consts.svh ----
// Constants for the common command and status unit
`ifndef CCSU_CONSTS_SVH
`define CCSU_CONSTS_SVH
`define CCSU_BIT_OPC      3'd7
`define CCSU_BIT_QYE      3'd5
`define CCSU_BIT_DDE      3'd4
`define CCSU_BIT_EXE      3'd3
`define CCSU_BIT_CME      3'd2
`define CCSU_BIT_PON      3'd0
`define CCSU_EVT_MASK     8'hBD
`define CCSU_ESE_RST      8'h00
`define CCSU_SRE_RST      8'h00
`define CCSU_ESR_RST      8'h01
`define CCSU_STB_ESB      3'd5
`define CCSU_ASCII_PLUS   8'h2B
`define CCSU_ASCII_ONE    8'h31
`define CCSU_ASCII_ZERO   8'h30
`define CCSU_MARGIN_DIV   10
`endif

// ---- core/ccsu_pkg.sv ----
// Types for the common command and status unit
package ccsu_pkg;
	typedef enum logic [3:0] {
		CCSU_CMD_NONE = 4'h0,
		CCSU_CMD_CLS  = 4'h1,
		CCSU_CMD_ESE  = 4'h2,
		CCSU_CMD_ESEQ = 4'h3,
		CCSU_CMD_ESRQ = 4'h4,
		CCSU_CMD_IDNQ = 4'h5,
		CCSU_CMD_OPC  = 4'h6,
		CCSU_CMD_OPCQ = 4'h7,
		CCSU_CMD_OPTQ = 4'h8,
		CCSU_CMD_RST  = 4'h9,
		CCSU_CMD_SRE  = 4'hA,
		CCSU_CMD_SREQ = 4'hB,
		CCSU_CMD_TRG  = 4'hC,
		CCSU_CMD_TSTQ = 4'hD,
		CCSU_CMD_WAI  = 4'hE,
		CCSU_CMD_ABOR = 4'hF
	} ccsu_cmd_t;
	typedef enum logic [1:0] {
		CCSU_ST_IDLE = 2'b00,
		CCSU_ST_OPCQ = 2'b01,
		CCSU_ST_WAI  = 2'b10
	} ccsu_state_t;
	typedef enum logic [1:0] {
		CCSU_OPT_NONE   = 2'b00,
		CCSU_OPT_RS_USB = 2'b01,
		CCSU_OPT_ANALOG = 2'b10,
		CCSU_OPT_GPIB   = 2'b11
	} ccsu_opt_t;
endpackage : ccsu_pkg

// ---- core/ccsu_unit.sv ----
// Common command interpreter with standard event status and trigger handling
`timescale 1ns/1ps
`include "ccsu_consts.svh"
// Function
// - Clear status zeroes events, keeps enables
// - Eight bit enable register, documented bit map
// - Command error sets bit 2
// - Execution error sets bit 3
// - Device error sets bit 4
// - Query error sets bit 5
// - Reset sets power-on bit 0
// - Enable query returns then clears register
// - Event query returns then clears events
// - Identification answers with the rsp_idn_o flag and a zero data byte
// - OPC bit set after pending operations finish
// - OPC query answers ASCII 1 when idle
// - Option query reports one interface code
// - Reset zeroes voltage and current settings, keeps power setting, limits rated plus a tenth
// - Service enable written, kept in storage
// - Service enable query returns then clears
// - Armed trigger command creates trigger event
// - Trigger loads triggered levels, clears waiting
// - Continuous mode rearms, waiting set again
// - Self test answers 0 pass, 1 fail
// - Wait holds commands until operations done
// - Abort disarms unless continuous mode
module ccsu_unit import ccsu_pkg::*; #(
	parameter int LW = 16
) (
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          nrst_i,
	// Parsed command
	input  wire logic          cmd_valid_i,
	input  wire ccsu_cmd_t     cmd_code_i,
	input  wire logic [7:0]    cmd_data_i,
	output logic               cmd_ready_o,
	// Error reports from parser and subsystems
	input  wire logic          err_cmd_i,
	input  wire logic          err_exe_i,
	input  wire logic          err_dev_i,
	input  wire logic          err_qry_i,
	// Overlapped operations and self test
	input  wire logic          ops_pending_i,
	input  wire logic          selftest_fail_i,
	input  wire ccsu_opt_t     option_i,
	// Transient subsystem
	input  wire logic          init_tran_i,
	input  wire logic          cont_tran_i,
	input  wire logic          trig_tran_i,
	input  wire logic [LW-1:0] rated_volt_i,
	input  wire logic [LW-1:0] rated_curr_i,
	input  wire logic [LW-1:0] trig_volt_i,
	input  wire logic [LW-1:0] trig_curr_i,
	input  wire logic [LW-1:0] trig_pow_i,
	// Non-volatile store of the service enable
	input  wire logic [7:0]    nv_sre_i,
	input  wire logic          nv_sre_load_i,
	output logic               nv_sre_wr_o,
	output logic [7:0]         nv_sre_data_o,
	// Responses
	output logic               rsp_valid_o,
	output logic [7:0]         rsp_data_o,
	output logic               rsp_idn_o,
	// Status
	output logic [7:0]         esr_o,
	output logic [7:0]         ese_o,
	output logic [7:0]         stb_o,
	output logic               status_clr_o,
	output logic               waiting_for_trigger_o,
	// Output programming
	output logic [LW-1:0]      volt_set_o,
	output logic [LW-1:0]      curr_set_o,
	output logic [LW-1:0]      pow_set_o,
	output logic [LW-1:0]      overvoltage_limit_o,
	output logic [LW-1:0]      overcurrent_limit_o
);
	// Level words narrower than the margin arithmetic or wider than the host are refused
	if (LW < 4 || LW > 32) begin : g_lw_bad
		$error("ccsu_unit: LW out of range");
	end

	logic        rst_s1_r, rst_n_r;
	ccsu_state_t state_r;
	logic        opc_arm_r;
	logic        take;
	logic [7:0]  evt_set;

	function automatic logic [LW-1:0] plus_margin(input logic [LW-1:0] v);
		plus_margin = v + LW'(v / LW'(`CCSU_MARGIN_DIV));
	endfunction : plus_margin

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	assign take = cmd_valid_i && cmd_ready_o;

	// Command sequencer; a held wait or an OPC query stalls further commands
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r     <= CCSU_ST_IDLE;
			cmd_ready_o <= 1'b0;
		end else begin
			case (state_r)
				CCSU_ST_IDLE: begin
					cmd_ready_o <= 1'b1;
					if (take && cmd_code_i == CCSU_CMD_WAI && ops_pending_i) begin
						state_r     <= CCSU_ST_WAI;
						cmd_ready_o <= 1'b0;
					end else if (take && cmd_code_i == CCSU_CMD_OPCQ) begin
						state_r     <= CCSU_ST_OPCQ;
						cmd_ready_o <= 1'b0;
					end
				end
				CCSU_ST_OPCQ, CCSU_ST_WAI: begin
					if (!ops_pending_i) begin
						state_r     <= CCSU_ST_IDLE;
						cmd_ready_o <= 1'b1;
					end
				end
				default: begin
					state_r     <= CCSU_ST_IDLE;
					cmd_ready_o <= 1'b0;
				end
			endcase
		end
	end

	// Response channel
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rsp_valid_o <= 1'b0;
			rsp_data_o  <= 8'h00;
			rsp_idn_o   <= 1'b0;
		end else begin
			rsp_valid_o <= 1'b0;
			rsp_idn_o   <= 1'b0;
			if (state_r == CCSU_ST_OPCQ && !ops_pending_i) begin
				rsp_valid_o <= 1'b1;
				rsp_data_o  <= `CCSU_ASCII_ONE;
			end else if (take) begin
				rsp_valid_o <= 1'b1;
				case (cmd_code_i)
					CCSU_CMD_ESEQ: rsp_data_o <= ese_o;
					CCSU_CMD_ESRQ: rsp_data_o <= esr_o;
					CCSU_CMD_SREQ: rsp_data_o <= nv_sre_data_o;
					CCSU_CMD_OPTQ: rsp_data_o <= {6'h00, option_i};
					CCSU_CMD_TSTQ: rsp_data_o <= selftest_fail_i ? `CCSU_ASCII_ONE
						: `CCSU_ASCII_ZERO;
					CCSU_CMD_IDNQ: begin
						rsp_data_o <= 8'h00;
						rsp_idn_o  <= 1'b1;
					end
					default: rsp_valid_o <= 1'b0;
				endcase
			end
		end
	end

	// Operation complete armed by the command, fired once idle
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			opc_arm_r <= 1'b0;
		end else if (take && cmd_code_i == CCSU_CMD_OPC) begin
			opc_arm_r <= 1'b1;
		end else if (!ops_pending_i) begin
			opc_arm_r <= 1'b0;
		end
	end

	// Event sources gathered for the standard event status register
	always_comb begin
		evt_set                = 8'h00;
		evt_set[`CCSU_BIT_CME] = err_cmd_i;
		evt_set[`CCSU_BIT_EXE] = err_exe_i;
		evt_set[`CCSU_BIT_DDE] = err_dev_i;
		evt_set[`CCSU_BIT_QYE] = err_qry_i;
		evt_set[`CCSU_BIT_OPC] = opc_arm_r && !ops_pending_i;
		evt_set[`CCSU_BIT_PON] = take && cmd_code_i == CCSU_CMD_RST;
	end

	// Standard event status; set wins over clear
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			esr_o <= `CCSU_ESR_RST;
		end else if (take && (cmd_code_i == CCSU_CMD_CLS || cmd_code_i == CCSU_CMD_ESRQ)) begin
			esr_o <= evt_set;
		end else begin
			esr_o <= esr_o | evt_set;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ese_o <= `CCSU_ESE_RST;
		end else if (take && cmd_code_i == CCSU_CMD_ESE) begin
			ese_o <= cmd_data_i & `CCSU_EVT_MASK;
		end else if (take && cmd_code_i == CCSU_CMD_ESEQ) begin
			ese_o <= 8'h00;
		end
	end

	// Service enable mirrored from and written to non-volatile store
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			nv_sre_data_o <= `CCSU_SRE_RST;
			nv_sre_wr_o   <= 1'b0;
		end else begin
			nv_sre_wr_o <= 1'b0;
			if (take && cmd_code_i == CCSU_CMD_SRE) begin
				nv_sre_data_o <= cmd_data_i;
				nv_sre_wr_o   <= 1'b1;
			end else if (take && cmd_code_i == CCSU_CMD_SREQ) begin
				nv_sre_data_o <= 8'h00;
			end else if (nv_sre_load_i) begin
				nv_sre_data_o <= nv_sre_i;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			stb_o        <= 8'h00;
			status_clr_o <= 1'b0;
		end else begin
			stb_o        <= 8'h00;
			stb_o[`CCSU_STB_ESB] <= |(esr_o & ese_o);
			status_clr_o <= take && cmd_code_i == CCSU_CMD_CLS;
		end
	end

	// Trigger system and output levels
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			waiting_for_trigger_o <= 1'b0;
			volt_set_o            <= '0;
			curr_set_o            <= '0;
			pow_set_o             <= '0;
			overvoltage_limit_o   <= '0;
			overcurrent_limit_o   <= '0;
		end else if (take && cmd_code_i == CCSU_CMD_RST) begin
			waiting_for_trigger_o <= 1'b0;
			volt_set_o            <= '0;
			curr_set_o            <= '0;
			overvoltage_limit_o   <= plus_margin(rated_volt_i);
			overcurrent_limit_o   <= plus_margin(rated_curr_i);
		end else if (waiting_for_trigger_o &&
			((take && cmd_code_i == CCSU_CMD_TRG) || trig_tran_i)) begin
			volt_set_o            <= trig_volt_i;
			curr_set_o            <= trig_curr_i;
			pow_set_o             <= trig_pow_i;
			waiting_for_trigger_o <= cont_tran_i;
		end else if (take && cmd_code_i == CCSU_CMD_ABOR && !cont_tran_i) begin
			waiting_for_trigger_o <= 1'b0;
		end else if (init_tran_i || cont_tran_i) begin
			waiting_for_trigger_o <= 1'b1;
		end
	end

	AST_UNARMED_TRG: assert property (@(posedge clk_i) disable iff (!rst_n_r)
		(!waiting_for_trigger_o && take && cmd_code_i == CCSU_CMD_TRG && !init_tran_i
		&& !cont_tran_i) |=> $stable(volt_set_o) && !waiting_for_trigger_o)
		else $error("unarmed trigger changed state");
	AST_CLS_KEEPS_ESE: assert property (@(posedge clk_i) disable iff (!rst_n_r)
		(take && cmd_code_i == CCSU_CMD_CLS && !err_cmd_i && !err_exe_i && !err_dev_i
		&& !err_qry_i) |=> $stable(ese_o) && (esr_o & 8'h7E) == 8'h00)
		else $error("clear status wrong");
	AST_ESEQ_CLEARS: assert property (@(posedge clk_i) disable iff (!rst_n_r)
		(take && cmd_code_i == CCSU_CMD_ESEQ) |=> rsp_valid_o && rsp_data_o == $past(ese_o)
		&& ese_o == 8'h00)
		else $error("enable query wrong");
	AST_CME_SET: assert property (@(posedge clk_i) disable iff (!rst_n_r)
		err_cmd_i |=> esr_o[2])
		else $error("command error not latched");
	AST_PON_RST: assert property (@(posedge clk_i) disable iff (!rst_n_r)
		(take && cmd_code_i == CCSU_CMD_RST) |=> esr_o[0] && volt_set_o == '0)
		else $error("reset effects missing");
	AST_WAI_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_r)
		(state_r == CCSU_ST_WAI && ops_pending_i) |=> !cmd_ready_o)
		else $error("commands taken during wait");
	AST_OPCQ_ANS: assert property (@(posedge clk_i) disable iff (!rst_n_r)
		(state_r == CCSU_ST_OPCQ && !ops_pending_i) |=> rsp_valid_o && rsp_data_o == 8'h31)
		else $error("opc query answer wrong");
	AST_TRG_LOAD: assert property (@(posedge clk_i) disable iff (!rst_n_r)
		(waiting_for_trigger_o && trig_tran_i && !(take && cmd_code_i == CCSU_CMD_RST))
		|=> volt_set_o == $past(trig_volt_i) && waiting_for_trigger_o == $past(cont_tran_i))
		else $error("trigger did not load levels");
	AST_ESB: assert property (@(posedge clk_i) disable iff (!rst_n_r)
		##1 stb_o[`CCSU_STB_ESB] == |($past(esr_o) & $past(ese_o)))
		else $error("summary bit wrong");
	AST_SREQ_CLEARS: assert property (@(posedge clk_i) disable iff (!rst_n_r)
		(take && cmd_code_i == CCSU_CMD_SREQ) |=> rsp_valid_o
		&& rsp_data_o == $past(nv_sre_data_o) && nv_sre_data_o == 8'h00)
		else $error("service enable query wrong");
	AST_CLS_PULSE: assert property (@(posedge clk_i) disable iff (!rst_n_r)
		(take && cmd_code_i == CCSU_CMD_CLS) |=> status_clr_o)
		else $error("clear status pulse missing");
	AST_ABOR_DISARM: assert property (@(posedge clk_i) disable iff (!rst_n_r)
		(take && cmd_code_i == CCSU_CMD_ABOR && !cont_tran_i && !trig_tran_i)
		|=> !waiting_for_trigger_o)
		else $error("abort left trigger armed");
endmodule : ccsu_unit

// ---- verification/ccsu_ctl_model.sv ----
// Behavioural remote controller that hands parsed commands to the unit
`timescale 1ns/1ps
module ccsu_ctl_model import ccsu_pkg::*; (
	// Clock
	input  wire logic       clk_i,
	// Unit answers
	input  wire logic       cmd_ready_i,
	input  wire logic       rsp_valid_i,
	input  wire logic [7:0] rsp_data_i,
	input  wire logic       rsp_idn_i,
	// Command lines
	output logic            cmd_valid_o,
	output ccsu_cmd_t       cmd_code_o,
	output logic [7:0]      cmd_data_o
);
	int answers = 0;
	initial begin
		cmd_valid_o = 1'b0;
		cmd_code_o  = CCSU_CMD_NONE;
		cmd_data_o  = 8'h00;
	end
	// Holds a command until taken; released lines carry the inverse of the last value
	task automatic xfer(input ccsu_cmd_t c, input logic [7:0] d, input bit q,
		output logic [8:0] r);
		int n;
		n = 0;
		cmd_code_o  = c;
		cmd_data_o  = d;
		cmd_valid_o = 1'b1;
		while (cmd_ready_i !== 1'b1 && n < 200) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		@(posedge clk_i);
		#1;
		cmd_valid_o = 1'b0;
		cmd_code_o  = ccsu_cmd_t'(~c);
		cmd_data_o  = ~d;
		r = 9'h000;
		while (q && rsp_valid_i !== 1'b1 && n < 400) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		if (q) begin
			r = {rsp_idn_i, rsp_data_i};
			answers++;
		end
		@(posedge clk_i);
		#1;
	endtask : xfer
endmodule : ccsu_ctl_model

// ---- verification/testbench.sv ----
// Self-checking bench for the common command and status unit
`timescale 1ns/1ps
module testbench;
	import ccsu_pkg::*;
	logic        clk_i, nrst, rdy, cv, rsv, idn, waiting_for_trigger, ops, stf, init_t, cont_t, trig_t, nvl;
	logic        nvw, scl;
	localparam int P_NVL = 4;
	localparam int P_INIT = 5;
	int          nvw_n = 0;
	int          scl_n = 0;
	ccsu_cmd_t   cc;
	ccsu_opt_t   opt;
	logic [3:0]  errs;
	logic [7:0]  cd, rd, esr, event_status_enable, stb, nvs, nvd;
	logic [15:0] rtv, rtc, tv, tc, tp, vset, cset, pset, ovl, ocl;
	logic [8:0]  r;
	int          miscompares = 0;
	int          compares = 0;
	int          cyc = 0;
	ccsu_unit #(.LW(16)) dut_u (.clk_i(clk_i), .nrst_i(nrst), .cmd_valid_i(cv),
		.cmd_code_i(cc), .cmd_data_i(cd), .cmd_ready_o(rdy), .err_cmd_i(errs[0]),
		.err_exe_i(errs[1]), .err_dev_i(errs[2]), .err_qry_i(errs[3]), .ops_pending_i(ops),
		.selftest_fail_i(stf), .option_i(opt), .init_tran_i(init_t), .cont_tran_i(cont_t),
		.trig_tran_i(trig_t), .rated_volt_i(rtv), .rated_curr_i(rtc), .trig_volt_i(tv),
		.trig_curr_i(tc), .trig_pow_i(tp), .nv_sre_i(nvs), .nv_sre_load_i(nvl),
		.nv_sre_wr_o(nvw), .nv_sre_data_o(nvd), .rsp_valid_o(rsv), .rsp_data_o(rd),
		.rsp_idn_o(idn), .esr_o(esr), .ese_o(event_status_enable), .stb_o(stb), .status_clr_o(scl),
		.waiting_for_trigger_o(waiting_for_trigger), .volt_set_o(vset), .curr_set_o(cset), .pow_set_o(pset),
		.overvoltage_limit_o(ovl), .overcurrent_limit_o(ocl));
	ccsu_ctl_model ctl_u (.clk_i(clk_i), .cmd_ready_i(rdy), .rsp_valid_i(rsv),
		.rsp_data_i(rd), .rsp_idn_i(idn), .cmd_valid_o(cv), .cmd_code_o(cc), .cmd_data_o(cd));
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	task automatic test_done;
		$display("Comparisons %0d mismatches %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : test_done
	always @(posedge clk_i) begin
		cyc++;
		if (nvw === 1'b1) nvw_n++;
		if (scl === 1'b1) scl_n++;
		if (cyc == 20000) begin
			miscompares++;
			test_done;
		end
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick
	// Strobe 0..3 are the error lines, then store load, arm, transient trigger
	task automatic pulse(input int k);
		if (k < 4) errs[k] = 1'b1;
		else if (k == P_NVL) nvl = 1'b1;
		else if (k == P_INIT) init_t = 1'b1;
		else trig_t = 1'b1;
		tick(1);
		{errs, nvl, init_t, trig_t} = 7'h00;
		tick(1);
	endtask : pulse
	task automatic cmd(input ccsu_cmd_t c, input logic [7:0] d);
		ctl_u.xfer(c, d, 1'b0, r);
	endtask : cmd
	task automatic ask(input ccsu_cmd_t c, input logic [8:0] e, input string nm);
		ctl_u.xfer(c, 8'h00, 1'b1, r);
		chk(nm, {7'h00, e}, {7'h00, r});
	endtask : ask
	task automatic t_events;
		cmd(CCSU_CMD_ESE, 8'hFF);
		ask(CCSU_CMD_ESEQ, 9'h0BD, "ese_rd");
		chk("ese_clr", 16'h0000, {8'h00, event_status_enable});
		cmd(CCSU_CMD_ESE, 8'h04);
		chk("esb_off", 16'h0000, {15'h0000, stb[5]});
		for (int i = 0; i < 4; i++) begin
			pulse(i);
			chk("esr_err", 16'h0001, {15'h0000, esr[i + 2]});
		end
		chk("esb_on", 16'h0001, {15'h0000, stb[5]});
		ask(CCSU_CMD_ESRQ, 9'h03D, "esr_rd");
		chk("esr_clr", 16'h0000, {8'h00, esr});
		pulse(1);
		cmd(CCSU_CMD_CLS, 8'h00);
		chk("cls_esr", 16'h0000, {8'h00, esr});
		chk("cls_ese", 16'h0004, {8'h00, event_status_enable});
		chk("cls_stb", 16'h0000, {8'h00, stb});
		chk("cls_pulse", 16'h0001, scl_n[15:0]);
	endtask : t_events
	task automatic t_queries;
		nvs = 8'hA5;
		pulse(P_NVL);
		ask(CCSU_CMD_SREQ, 9'h0A5, "sre_nv");
		cmd(CCSU_CMD_SRE, 8'h5A);
		chk("sre_store", 16'h005A, {8'h00, nvd});
		chk("sre_nv_wr", 16'h0001, nvw_n[15:0]);
		ask(CCSU_CMD_SREQ, 9'h05A, "sre_rd");
		ask(CCSU_CMD_SREQ, 9'h000, "sre_clr");
		for (int i = 0; i < 4; i++) begin
			opt = ccsu_opt_t'(i[1:0]);
			ask(CCSU_CMD_OPTQ, {7'h00, i[1:0]}, "opt");
		end
		stf = 1'b1;
		ask(CCSU_CMD_TSTQ, 9'h031, "tst_fail");
		stf = 1'b0;
		ask(CCSU_CMD_TSTQ, 9'h030, "tst_pass");
		ctl_u.xfer(CCSU_CMD_IDNQ, 8'h00, 1'b1, r);
		chk("idn", 16'h0001, {15'h0000, r[8]});
	endtask : t_queries
	task automatic t_sync;
		int a;
		ops = 1'b1;
		cmd(CCSU_CMD_OPC, 8'h00);
		tick(3);
		chk("opc_early", 16'h0000, {15'h0000, esr[7]});
		ops = 1'b0;
		tick(3);
		chk("opc_set", 16'h0001, {15'h0000, esr[7]});
		ops = 1'b1;
		a = ctl_u.answers;
		fork
			ask(CCSU_CMD_OPCQ, 9'h031, "opcq");
			begin
				tick(6);
				chk("opcq_held", a, ctl_u.answers);
				chk("opcq_busy", 16'h0000, {15'h0000, rdy});
				ops = 1'b0;
			end
		join
		ops = 1'b1;
		cmd(CCSU_CMD_WAI, 8'h00);
		tick(4);
		chk("wai_hold", 16'h0000, {15'h0000, rdy});
		ops = 1'b0;
		tick(3);
		chk("wai_free", 16'h0001, {15'h0000, rdy});
	endtask : t_sync
	task automatic t_trig;
		cmd(CCSU_CMD_TRG, 8'h00);
		chk("idle_wtg", 16'h0000, {15'h0000, waiting_for_trigger});
		chk("idle_volt", 16'h0000, vset);
		pulse(P_INIT);
		chk("armed", 16'h0001, {15'h0000, waiting_for_trigger});
		cmd(CCSU_CMD_TRG, 8'h00);
		chk("trg_volt", tv, vset);
		chk("trg_curr", tc, cset);
		chk("trg_pow", tp, pset);
		chk("trg_wtg", 16'h0000, {15'h0000, waiting_for_trigger});
		tv = 16'h2222;
		cont_t = 1'b1;
		tick(2);
		pulse(6);
		chk("cont_volt", 16'h2222, vset);
		chk("cont_wtg", 16'h0001, {15'h0000, waiting_for_trigger});
		cmd(CCSU_CMD_ABOR, 8'h00);
		chk("abor_cont", 16'h0001, {15'h0000, waiting_for_trigger});
		cont_t = 1'b0;
		pulse(P_INIT);
		cmd(CCSU_CMD_ABOR, 8'h00);
		chk("abor_wtg", 16'h0000, {15'h0000, waiting_for_trigger});
		tv = 16'h3333;
		cmd(CCSU_CMD_TRG, 8'h00);
		chk("abor_volt", 16'h2222, vset);
		cmd(CCSU_CMD_RST, 8'h00);
		chk("rst_volt", 16'h0000, vset);
		chk("rst_curr", 16'h0000, cset);
	endtask : t_trig
	initial begin
		{nrst, ops, stf, init_t, cont_t, trig_t, nvl, errs} = 11'h000;
		opt = CCSU_OPT_NONE;
		{rtv, rtc, tv, tc, tp} = {16'd1000, 16'd500, 16'h1234, 16'h0567, 16'h0ABC};
		nvs = 8'h00;
		tick(16);
		nrst = 1'b1;
		tick(1);
		chk("pon", 16'h0001, {8'h00, esr});
		cmd(CCSU_CMD_RST, 8'h00);
		chk("ovl", rtv + rtv / 16'h000A, ovl);
		chk("ocl", rtc + rtc / 16'h000A, ocl);
		t_events();
		t_queries();
		t_sync();
		t_trig();
		test_done;
	end
endmodule : testbench
